// ===== include/vsf_pkg.sv
package vsf_pkg;
  // ==========================================================
  // Timing
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int SEQ_CLK_HZ = 60;
  localparam int SEQ_TICK_CYCLES = SYS_CLK_HZ / SEQ_CLK_HZ;
  localparam int TICKS_PER_STEP = 4;
  localparam int FAST_TIME_US = 1000;
  localparam int FAST_LIMIT_CYCLES = FAST_TIME_US * (SYS_CLK_HZ / 1_000_000);

  // ==========================================================
  // Gain scale
  localparam int VOL_W = 10;
  localparam int GAIN_W = 6;
  localparam int PROD_W = 20;
  localparam int MUL_W = 8;
  localparam int NUM_STEPS = 32;
  localparam int HYS_DIV = 4;
  localparam logic [GAIN_W-1:0] MUTE_GAIN = 6'h00;
  localparam logic [GAIN_W-1:0] GAIN_STEP = 6'h01;
  localparam logic [GAIN_W-1:0] MAX_TARGET = 6'h1F;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    VSF_OFF,
    VSF_RUN,
    VSF_FADE_OUT
  } vsf_mode_t;

  typedef struct packed {
    logic shutdownN;
    logic mute;
    logic fadeHigh;
    logic shortDetect;
  } vsf_pins_t;

  typedef struct packed {
    logic outputEnable;
    logic lowPower;
    logic faultLatched;
    logic atTarget;
  } vsf_status_t;

  typedef struct packed {
    vsf_pins_t sync1;
    vsf_pins_t sync2;
    vsf_mode_t mode;
    logic [GAIN_W-1:0] target;
    logic [GAIN_W-1:0] gain;
    vsf_status_t status;
  } vsf_state_t;

  localparam vsf_state_t STATE_RESET = '0;
endpackage

// ===== src/vsf_tick_div.sv
`timescale 1ns/100ps
module vsf_tick_div #(
  parameter int DIV = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic enable,
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  typedef struct packed {
    logic [CW-1:0] count;
    logic tick;
  } vsf_div_state_t;

  vsf_div_state_t s_q;
  vsf_div_state_t s_d;

  // ==========================================================
  // Counts enable pulses, one tick per DIV of them
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (enable) begin
      if (s_q.count == CW'(DIV - 1)) begin
        s_d.count = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.count = s_q.count + CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

// ===== src/vsf_controller.sv
`timescale 1ns/100ps
// What this block does
// R01 - Target step from volume over reference
// R02 - Different rising and falling step thresholds
// R03 - One step per four 60 Hz ticks
// R04 - Fade mode: ramp up from mute
// R05 - Fade mode: shutdown ramps down to mute
// R06 - Fast mode: jump to target quickly
// R07 - Fast mode: shutdown mutes within 1 ms
// R08 - Mute input gates outputs immediately; here outputEnable drops three clocks after the pin, behind two sync flops
// R09 - Shutdown low mutes and enters low power
// R10 - Controller drives mute and shutdown defined; here both are inputs, synchronised through two flops
// R11 - Controller keeps two threshold tables; here upThr and dnThr are computed from the target, with no tables
// R12 - Controller asserts shutdown before supply removal; this block has no supply input and only samples shutdownN
// R13 - Short latches fault, shutdown cycle clears
// R14 - Gain index mute at reset and shutdown
module vsf_controller #(
  parameter int SEQ_TICK_CYCLES = vsf_pkg::SEQ_TICK_CYCLES,
  parameter int TICKS_PER_STEP = vsf_pkg::TICKS_PER_STEP
) (
  input wire logic sys_clk,
  input wire logic reset,
  input vsf_pkg::vsf_pins_t pins,
  input wire logic [vsf_pkg::VOL_W-1:0] volumeCode,
  input wire logic [vsf_pkg::VOL_W-1:0] referenceCode,
  output logic [vsf_pkg::GAIN_W-1:0] gainIndex,
  output logic [vsf_pkg::GAIN_W-1:0] targetIndex,
  output vsf_pkg::vsf_status_t status
);
  vsf_pkg::vsf_state_t s_q;
  vsf_pkg::vsf_state_t s_d;
  logic seqTick;
  logic stepTick;
  logic [vsf_pkg::PROD_W-1:0] scaled;
  logic [vsf_pkg::PROD_W-1:0] upThr;
  logic [vsf_pkg::PROD_W-1:0] dnThr;
  logic [vsf_pkg::MUL_W-1:0] upMul;
  logic [vsf_pkg::MUL_W-1:0] dnMul;
  logic [vsf_pkg::GAIN_W-1:0] desired;
  logic sdN;
  logic fadeHi;

  // ==========================================================
  // Sequencing clock and step pulse
  vsf_tick_div #(.DIV(SEQ_TICK_CYCLES)) u_seq_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(1'b1),
    .tick(seqTick)
  );

  vsf_tick_div #(.DIV(TICKS_PER_STEP)) u_step_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(seqTick), // R03
    .tick(stepTick)
  );

  // ==========================================================
  // Step thresholds, quarter-step band around each boundary
  always_comb begin
    scaled = vsf_pkg::PROD_W'(volumeCode) *
             vsf_pkg::PROD_W'(vsf_pkg::NUM_STEPS * vsf_pkg::HYS_DIV); // R01
    upMul = vsf_pkg::MUL_W'(vsf_pkg::HYS_DIV * (int'(s_q.target) + 1) + 1);
    dnMul = (s_q.target == vsf_pkg::MUTE_GAIN) ? '0 :
            vsf_pkg::MUL_W'(vsf_pkg::HYS_DIV * int'(s_q.target) - 1); // R02
    upThr = vsf_pkg::PROD_W'(referenceCode) * vsf_pkg::PROD_W'(upMul);
    dnThr = vsf_pkg::PROD_W'(referenceCode) * vsf_pkg::PROD_W'(dnMul);
  end

  assign desired = s_q.target + vsf_pkg::GAIN_STEP;
  assign sdN = s_q.sync2.shutdownN;
  assign fadeHi = s_q.sync2.fadeHigh;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.sync1 = pins; // R10
    s_d.sync2 = s_q.sync1;

    if (s_q.target != vsf_pkg::MAX_TARGET && scaled >= upThr) begin
      s_d.target = s_q.target + vsf_pkg::GAIN_STEP; // R01
    end else if (s_q.target != vsf_pkg::MUTE_GAIN && scaled < dnThr) begin
      s_d.target = s_q.target - vsf_pkg::GAIN_STEP; // R02
    end

    case (s_q.mode)
      vsf_pkg::VSF_OFF: begin
        s_d.gain = vsf_pkg::MUTE_GAIN; // R14
        if (sdN) begin
          s_d.mode = vsf_pkg::VSF_RUN; // R04
        end
      end
      vsf_pkg::VSF_RUN: begin
        if (!sdN) begin
          if (!fadeHi && s_q.gain != vsf_pkg::MUTE_GAIN) begin
            s_d.mode = vsf_pkg::VSF_FADE_OUT; // R05
          end else begin
            s_d.mode = vsf_pkg::VSF_OFF; // R07
            s_d.gain = vsf_pkg::MUTE_GAIN; // R14
          end
        end else if (fadeHi) begin
          s_d.gain = desired; // R06
        end else if (stepTick) begin
          if (s_q.gain < desired) begin
            s_d.gain = s_q.gain + vsf_pkg::GAIN_STEP; // R04
          end else if (s_q.gain > desired) begin
            s_d.gain = s_q.gain - vsf_pkg::GAIN_STEP; // R03
          end
        end
      end
      vsf_pkg::VSF_FADE_OUT: begin
        if (sdN) begin
          s_d.mode = vsf_pkg::VSF_RUN;
        end else if (fadeHi || s_q.gain == vsf_pkg::MUTE_GAIN) begin
          s_d.mode = vsf_pkg::VSF_OFF; // R07
          s_d.gain = vsf_pkg::MUTE_GAIN;
        end else if (stepTick) begin
          s_d.gain = s_q.gain - vsf_pkg::GAIN_STEP; // R05
          if (s_q.gain == vsf_pkg::GAIN_STEP) begin
            s_d.mode = vsf_pkg::VSF_OFF;
          end
        end
      end
      default: begin
        s_d.mode = vsf_pkg::VSF_OFF;
        s_d.gain = vsf_pkg::MUTE_GAIN;
      end
    endcase

    // Set wins over the shutdown clear
    if (s_q.sync2.shortDetect) begin
      s_d.status.faultLatched = 1'b1; // R13
    end else if (!sdN) begin
      s_d.status.faultLatched = 1'b0; // R13
    end

    s_d.status.lowPower = (s_d.mode == vsf_pkg::VSF_OFF); // R09
    s_d.status.outputEnable = (s_d.mode != vsf_pkg::VSF_OFF) &&
                              !s_q.sync2.mute &&
                              !s_d.status.faultLatched; // R08
    s_d.status.atTarget = (s_d.gain == s_d.target + vsf_pkg::GAIN_STEP);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= vsf_pkg::STATE_RESET; // R14
    end else begin
      s_q <= s_d;
    end
  end

  assign gainIndex = s_q.gain;
  assign targetIndex = s_q.target;
  assign status = s_q.status;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence fadeStep;
    s_q.mode == vsf_pkg::VSF_FADE_OUT && stepTick && !sdN && !fadeHi &&
    s_q.gain != vsf_pkg::MUTE_GAIN;
  endsequence

  sequence runFast;
    s_q.mode == vsf_pkg::VSF_RUN && sdN && fadeHi;
  endsequence

  AST_TARGET_UP: assert property ( // R01
    (s_q.target != vsf_pkg::MAX_TARGET && scaled >= upThr) |=>
      s_q.target == $past(s_q.target) + vsf_pkg::GAIN_STEP)
    else $error("Target did not rise");

  AST_HYST_HOLD: assert property ( // R02
    (scaled < upThr && scaled >= dnThr) |=> $stable(s_q.target))
    else $error("Target moved inside hysteresis band");

  AST_STEP_RATE: assert property ( // R03
    (s_q.mode == vsf_pkg::VSF_RUN && sdN && !fadeHi && !stepTick) |=>
      $stable(s_q.gain))
    else $error("Gain changed without step tick");

  AST_RAMP_UP: assert property ( // R04
    (s_q.mode == vsf_pkg::VSF_RUN && sdN && !fadeHi && stepTick &&
     s_q.gain < desired) |=> s_q.gain == $past(s_q.gain) + vsf_pkg::GAIN_STEP)
    else $error("Fade ramp up not one step");

  AST_FADE_DOWN: assert property ( // R05
    fadeStep |=> s_q.gain == $past(s_q.gain) - vsf_pkg::GAIN_STEP)
    else $error("Fade ramp down not one step");

  AST_FAST_UP: assert property ( // R06
    runFast |=> s_q.gain == $past(desired))
    else $error("Fast mode did not reach target");

  AST_FAST_DOWN: assert property ( // R07
    (s_q.mode != vsf_pkg::VSF_OFF && !sdN && fadeHi) |=>
      s_q.mode == vsf_pkg::VSF_OFF && s_q.gain == vsf_pkg::MUTE_GAIN)
    else $error("Fast shutdown did not mute");

  AST_MUTE_GATE: assert property ( // R08
    s_q.sync2.mute |=> !s_q.status.outputEnable)
    else $error("Outputs enabled while muted");

  AST_SD_LOWPOWER: assert property ( // R09
    (s_q.mode == vsf_pkg::VSF_OFF && !sdN) |=>
      s_q.status.lowPower && !s_q.status.outputEnable)
    else $error("Shutdown not in low power");

  AST_FAULT_LATCH: assert property ( // R13
    s_q.sync2.shortDetect |=>
      s_q.status.faultLatched && !s_q.status.outputEnable)
    else $error("Short did not latch fault");

  AST_FAULT_HOLD: assert property ( // R13
    (s_q.status.faultLatched && sdN) |=> s_q.status.faultLatched)
    else $error("Fault cleared without shutdown");

  AST_OFF_MUTE: assert property ( // R14
    s_q.mode == vsf_pkg::VSF_OFF |-> s_q.gain == vsf_pkg::MUTE_GAIN)
    else $error("Gain not mute in shutdown");

  AST_RAMP_DOWN: assert property ( // R03
    (s_q.mode == vsf_pkg::VSF_RUN && sdN && !fadeHi && stepTick &&
     s_q.gain > desired) |=> s_q.gain == $past(s_q.gain) - vsf_pkg::GAIN_STEP)
    else $error("Run ramp down not one step");

  sequence fadeResume;
    s_q.mode == vsf_pkg::VSF_FADE_OUT && sdN;
  endsequence

  AST_FADE_RESUME: assert property ( // R04
    fadeResume |=> s_q.mode == vsf_pkg::VSF_RUN && $stable(s_q.gain))
    else $error("Fade out did not resume run");

  AST_AT_TARGET: assert property ( // R03
    s_q.status.atTarget == (s_q.gain == s_q.target + vsf_pkg::GAIN_STEP))
    else $error("Target flag does not match gain");
endmodule

// ===== tb/vsf_host_model.sv
`timescale 1ns/100ps
module vsf_host_model (
  input wire logic sys_clk,
  output vsf_pkg::vsf_pins_t pins,
  output logic [vsf_pkg::VOL_W-1:0] volumeCode,
  output logic [vsf_pkg::VOL_W-1:0] referenceCode
);
  // ==========================================================
  // Control pins
  initial begin
    pins = '{1'b1, 1'b0, 1'b1, 1'b0};
    volumeCode = 10'h040;
    referenceCode = 10'h080;
  end

  // Drives all four control pins together after a falling clock edge
  task automatic drivePins(input logic sd, mu, fd, sh);
    @(negedge sys_clk);
    pins = '{sd, mu, fd, sh};
  endtask

  // Caller picks rising or falling trip code
  task automatic driveVolume(input logic [9:0] code);
    @(negedge sys_clk);
    volumeCode = code;
  endtask

  // Reference sets the full scale of the volume fraction
  task automatic driveReference(input logic [9:0] code);
    @(negedge sys_clk);
    referenceCode = code;
  endtask
endmodule

// ===== tb/vsf_controller_test.sv
`timescale 1ns/100ps
module vsf_controller_test;
  logic sys_clk;
  logic reset;
  vsf_pkg::vsf_pins_t pins;
  logic [vsf_pkg::VOL_W-1:0] volumeCode;
  logic [vsf_pkg::VOL_W-1:0] referenceCode;
  logic [vsf_pkg::GAIN_W-1:0] gainIndex;
  logic [vsf_pkg::GAIN_W-1:0] targetIndex;
  vsf_pkg::vsf_status_t status;
  int errorCnt = 0;
  int nTests = 0;
  int cycleCnt = 0;
  int gap;

  vsf_host_model i_host (.sys_clk(sys_clk), .pins(pins),
    .volumeCode(volumeCode), .referenceCode(referenceCode));

  vsf_controller #(.SEQ_TICK_CYCLES(8), .TICKS_PER_STEP(4)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .pins(pins),
    .volumeCode(volumeCode), .referenceCode(referenceCode),
    .gainIndex(gainIndex), .targetIndex(targetIndex), .status(status));

  // ==========================================================
  // Clock and timeout
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 4000) begin
      errorCnt++;
      giveVerdict();
    end
  end

  // ==========================================================
  // Helpers
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic giveVerdict();
    if (errorCnt == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic waitGain(input logic [5:0] exp, input int bound);
    int n;
    n = 0;
    while (gainIndex !== exp && n < bound) begin
      @(negedge sys_clk);
      n++;
    end
    cmp({2'b00, gainIndex}, {2'b00, exp});
  endtask

  // Cycles between two gain steps, each step checked for size
  task automatic stepGap(input logic [5:0] delta, output int cnt);
    logic [5:0] old;
    int n;
    old = gainIndex;
    n = 0;
    while (gainIndex === old && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    cmp({2'b00, gainIndex}, {2'b00, old + delta});
    old = gainIndex;
    cnt = 0;
    while (gainIndex === old && cnt < 40) begin
      @(negedge sys_clk);
      cnt++;
    end
    cmp({2'b00, gainIndex}, {2'b00, old + delta});
  endtask

  // ==========================================================
  // Tests
  initial begin
    reset = 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp({2'b00, gainIndex}, 8'h00);
    cmp({4'h0, status}, 8'h00);
    reset = 1'b0;
    waitCyc(40);
    cmp({2'b00, targetIndex}, 8'h0F);
    cmp({2'b00, gainIndex}, 8'h10);
    cmp({4'h0, status}, 8'h09);
    i_host.driveVolume(10'h03C);
    waitCyc(10);
    cmp({2'b00, targetIndex}, 8'h0F);
    i_host.driveVolume(10'h03A);
    waitCyc(10);
    cmp({2'b00, targetIndex}, 8'h0E);
    i_host.driveVolume(10'h03C);
    waitCyc(10);
    cmp({2'b00, targetIndex}, 8'h0E);
    cmp({2'b00, gainIndex}, 8'h0F);
    i_host.drivePins(1'b1, 1'b1, 1'b1, 1'b0);
    waitCyc(4);
    cmp({4'h0, status}, 8'h01);
    cmp({2'b00, gainIndex}, 8'h0F);
    i_host.drivePins(1'b1, 1'b0, 1'b1, 1'b0);
    waitCyc(4);
    cmp({4'h0, status}, 8'h09);
    i_host.drivePins(1'b0, 1'b0, 1'b1, 1'b0);
    waitCyc(4);
    cmp({2'b00, gainIndex}, 8'h00);
    cmp({4'h0, status}, 8'h04);
    i_host.drivePins(1'b1, 1'b0, 1'b0, 1'b0);
    stepGap(6'h01, gap);
    cmp(gap[7:0], 8'h20);
    cmp({2'b00, gainIndex}, 8'h02);
    waitGain(6'h0F, 500);
    cmp({4'h0, status}, 8'h09);
    i_host.drivePins(1'b0, 1'b0, 1'b0, 1'b0);
    waitCyc(4);
    cmp({6'h00, status.outputEnable, status.lowPower}, 8'h02);
    stepGap(6'h3F, gap);
    cmp(gap[7:0], 8'h20);
    waitGain(6'h00, 500);
    waitCyc(1);
    cmp({4'h0, status}, 8'h04);
    i_host.drivePins(1'b1, 1'b0, 1'b1, 1'b0);
    waitCyc(10);
    i_host.drivePins(1'b1, 1'b0, 1'b1, 1'b1);
    waitCyc(4);
    i_host.drivePins(1'b1, 1'b0, 1'b1, 1'b0);
    waitCyc(4);
    cmp({4'h0, status}, 8'h03);
    i_host.drivePins(1'b0, 1'b0, 1'b1, 1'b0);
    waitCyc(4);
    i_host.drivePins(1'b1, 1'b0, 1'b1, 1'b0);
    waitCyc(10);
    cmp({4'h0, status}, 8'h09);
    i_host.drivePins(1'b1, 1'b0, 1'b0, 1'b0);
    waitCyc(4);
    i_host.driveReference(10'h100);
    stepGap(6'h3F, gap);
    cmp(gap[7:0], 8'h20);
    waitGain(6'h08, 300);
    cmp({2'b00, targetIndex}, 8'h07);
    cmp({4'h0, status}, 8'h09);
    i_host.drivePins(1'b0, 1'b0, 1'b0, 1'b0);
    stepGap(6'h3F, gap);
    cmp(gap[7:0], 8'h20);
    cmp({6'h00, status.outputEnable, status.lowPower}, 8'h02);
    i_host.drivePins(1'b1, 1'b0, 1'b0, 1'b0);
    waitGain(6'h08, 200);
    cmp({4'h0, status}, 8'h09);
    i_host.drivePins(1'b0, 1'b0, 1'b0, 1'b0);
    waitCyc(4);
    cmp({6'h00, status.outputEnable, status.lowPower}, 8'h02);
    i_host.drivePins(1'b0, 1'b0, 1'b1, 1'b0);
    waitCyc(4);
    cmp({2'b00, gainIndex}, 8'h00);
    cmp({4'h0, status}, 8'h04);
    i_host.drivePins(1'b0, 1'b0, 1'b1, 1'b0);
    waitCyc(4);
    giveVerdict();
  end
endmodule
